// ==== fcs_sequencer.sv ====
// Flash command sequencer: APB register file, mode select, command launch.
// Assumes a single 25 MHz clock and an APB master keeping the bus protocol.
//
// Summary of operation
// - Mode field selects read, code P/E, data P/E
// - Codes program, block erase, all erase start
// - Code three starts a blank check
// - Extra code one programs start-up or protects
// - Extra code two programs window info
// - Done interrupt on completion or forced stop
// - Start-up protection guards blocks zero to seven
// - Area protection refuses blocks outside window
// - Code fetch continues during data P/E
// - Start address upper half is 16 bits
// - End address upper half is 16 bits
// - Error address upper half is reported
// - Four indexed write buffer words
// - Four indexed 32-bit identifier words
// - Flag shows window protection in force
// - Code flash decoded FFFC0000 to FFFFFFFF
// - Data flash decoded from 00100000, 8 or 4 KB
`timescale 1ns/1ps
module fcs_sequencer #(
  parameter logic [15:0] DATA_LAST_UPPER = 16'h0010,
  parameter int OP_LEN = fcs_pkg::OP_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic force_stop_i,
  output logic command_done_interrupt_o,
  output logic background_operation_o,
  output logic code_fetch_ok_o,
  output logic [1:0] flash_mode_o
);
  import fcs_pkg::*;

  // ----------------------------------------------------------------
  // State and registers
  // ----------------------------------------------------------------
  fcs_cmd_if cmd_bus ();
  fcs_state_type state_reg;
  logic [1:0] flash_mode_control_reg;
  logic [5:0] clock_notification_field_reg;
  logic [3:0] main_cmd_reg;
  logic [2:0] extra_cmd_reg;
  logic [15:0] start_address_upper_reg;
  logic [15:0] end_address_upper_reg;
  logic [15:0] error_address_upper_reg;
  logic [31:0] write_buffer_word_reg [4];
  logic [7:0] area_lo_reg;
  logic [7:0] area_hi_reg;
  logic startup_protect_reg;
  logic window_protect_flag_reg;
  logic done_reg;
  logic err_reg;
  logic irq_reg;
  logic bgo_reg;
  logic fetch_ok_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] uid_word;
  logic wr_acc;
  logic rd_acc;
  logic start_pulse;
  logic cmd_ok;
  logic refuse;
  logic in_code;
  logic in_data;
  logic [7:0] blk_idx;
  logic is_main;

  fcs_op_timer #(.CYCLES(OP_LEN)) u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cmd(cmd_bus.timer)
  );

  fcs_uid_rom u_uid (
    .index_i(paddr_i[3:2]),
    .word_o(uid_word)
  );

  // ----------------------------------------------------------------
  // APB access decode
  // ----------------------------------------------------------------
  // One-wait slave: act in the first access cycle, raise pready in the second
  assign wr_acc = psel_i && penable_i && pwrite_i && !pready_reg;
  assign rd_acc = psel_i && penable_i && !pwrite_i && !pready_reg;

  // Address range checks on the upper halves
  assign in_code = (start_address_upper_reg >= CODE_UPPER_LO);
  assign in_data = (start_address_upper_reg >= DATA_UPPER)
                   && (end_address_upper_reg <= DATA_LAST_UPPER);
  assign blk_idx = start_address_upper_reg[7:0];

  // Command legality; main area needs matching mode
  always_comb begin
    cmd_ok = 1'b0;
    is_main = 1'b0;
    refuse = 1'b0;
    if (wr_acc && paddr_i == OFS_MAINCMD) begin
      is_main = 1'b1;
      case (pwdata_i[3:0])
        CMD_PROGRAM, CMD_BLOCK_ERASE, CMD_ALL_ERASE: cmd_ok = 1'b1;
        CMD_BLANK: cmd_ok = 1'b1;
        default: cmd_ok = 1'b0;
      endcase
      // Mode and address must agree
      if (flash_mode_control_reg == MODE_CODE_PE) begin
        refuse = !in_code;
        // Boot unit holds blocks 0..7; locked under start-up protection
        if (startup_protect_reg && start_address_upper_reg == BOOT_UPPER_HI
            && pwdata_i[3:0] != CMD_BLANK) begin
          refuse = 1'b1;
        end
        // Outside the allowed user window, refuse
        if (pwdata_i[3:0] != CMD_BLANK
            && (blk_idx < area_lo_reg || blk_idx > area_hi_reg)) begin
          refuse = 1'b1;
        end
      end else if (flash_mode_control_reg == MODE_DATA_PE) begin
        refuse = !in_data;
      end else begin
        refuse = 1'b1;
      end
    end else if (wr_acc && paddr_i == OFS_EXTCMD) begin
      case (pwdata_i[2:0])
        XCMD_STARTUP: cmd_ok = 1'b1;
        XCMD_WINDOW: cmd_ok = 1'b1;
        default: cmd_ok = 1'b0;
      endcase
      refuse = (flash_mode_control_reg != MODE_CODE_PE);
    end
  end

  // Launch only from idle; commands written while busy are dropped without setting the error flag
  assign start_pulse = cmd_ok && !refuse && state_reg == ST_IDLE;
  assign cmd_bus.start = start_pulse;
  assign cmd_bus.abort = force_stop_i;

  // ----------------------------------------------------------------
  // Command state machine
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start_pulse) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (cmd_bus.done) begin
            state_reg <= ST_FINISH;
          end
        end
        ST_FINISH: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Completion pulse: once per command, also after forced stop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= (state_reg == ST_RUN) && cmd_bus.done;
    end
  end

  // Done flag: set beats clear by status read-write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_reg <= 1'b0;
    end else if (state_reg == ST_RUN && cmd_bus.done) begin
      done_reg <= 1'b1;
    end else if (wr_acc && paddr_i == OFS_STATUS && pwdata_i[ST_DONE]) begin
      done_reg <= 1'b0;
    end
  end

  // Error flag and error address on refused command
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_reg <= 1'b0;
      error_address_upper_reg <= 16'h0000;
    end else if (cmd_ok && refuse) begin
      err_reg <= 1'b1;
      error_address_upper_reg <= start_address_upper_reg;
    end else if (wr_acc && paddr_i == OFS_STATUS && pwdata_i[ST_ERR]) begin
      err_reg <= 1'b0;
    end
  end

  // Background operation: data P/E keeps code fetch alive
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bgo_reg <= 1'b0;
      fetch_ok_reg <= 1'b1;
    end else begin
      bgo_reg <= (state_reg != ST_IDLE) && flash_mode_control_reg == MODE_DATA_PE;
      fetch_ok_reg <= (flash_mode_control_reg != MODE_CODE_PE);
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flash_mode_control_reg <= MODE_READ;
      clock_notification_field_reg <= 6'h00;
      main_cmd_reg <= 4'h0;
      extra_cmd_reg <= 3'h0;
      start_address_upper_reg <= 16'h0000;
      end_address_upper_reg <= 16'h0000;
      area_lo_reg <= 8'h00;
      area_hi_reg <= 8'hFF;
      startup_protect_reg <= 1'b0;
    end else if (wr_acc) begin
      case (paddr_i)
        // Prohibited code 11 ignored, mode kept
        OFS_MODE: begin
          if (state_reg == ST_IDLE && pwdata_i[1:0] != 2'h3) begin
            flash_mode_control_reg <= pwdata_i[1:0];
          end
        end
        OFS_CLKSET: clock_notification_field_reg <= pwdata_i[5:0];
        OFS_MAINCMD: if (start_pulse) main_cmd_reg <= pwdata_i[3:0];
        OFS_EXTCMD: if (start_pulse) extra_cmd_reg <= pwdata_i[2:0];
        OFS_START: start_address_upper_reg <= pwdata_i[15:0];
        OFS_END: end_address_upper_reg <= pwdata_i[15:0];
        OFS_PROTECT: begin
          area_lo_reg <= pwdata_i[7:0];
          area_hi_reg <= pwdata_i[15:8];
          startup_protect_reg <= pwdata_i[16];
        end
        default: ;
      endcase
    end
  end

  // Window protect flag set by extra command one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      window_protect_flag_reg <= 1'b0;
    end else if (start_pulse && !is_main && pwdata_i[2:0] == XCMD_STARTUP) begin
      window_protect_flag_reg <= 1'b1;
    end
  end

  // Write buffer words indexed by address
  for (genvar g = 0; g < 4; g++) begin : g_wbuf
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        write_buffer_word_reg[g] <= 32'h0000_0000;
      end else if (wr_acc && paddr_i == (OFS_WBUF | 8'(g * 4))) begin
        write_buffer_word_reg[g] <= pwdata_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path and APB answer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= psel_i && penable_i && !pready_reg;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      if (rd_acc) begin
        case (paddr_i & OFS_BLOCK_MASK)
          OFS_WBUF: prdata_reg <= write_buffer_word_reg[paddr_i[3:2]];
          OFS_UID: prdata_reg <= uid_word;
          default: begin
            case (paddr_i)
              OFS_MODE: prdata_reg <= {30'h0, flash_mode_control_reg};
              OFS_CLKSET: prdata_reg <= {26'h0, clock_notification_field_reg};
              OFS_MAINCMD: prdata_reg <= {28'h0, main_cmd_reg};
              OFS_EXTCMD: prdata_reg <= {29'h0, extra_cmd_reg};
              OFS_START: prdata_reg <= {16'h0, start_address_upper_reg};
              OFS_END: prdata_reg <= {16'h0, end_address_upper_reg};
              OFS_ERRADDR: prdata_reg <= {16'h0, error_address_upper_reg};
              OFS_STATUS: prdata_reg <= {27'h0, bgo_reg, window_protect_flag_reg,
                                         err_reg, done_reg, state_reg != ST_IDLE};
              OFS_PROTECT: prdata_reg <= {15'h0, startup_protect_reg,
                                          area_hi_reg, area_lo_reg};
              default: pslverr_reg <= 1'b1;
            endcase
          end
        endcase
      end
    end
  end

  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign command_done_interrupt_o = irq_reg;
  assign background_operation_o = bgo_reg;
  assign code_fetch_ok_o = fetch_ok_reg;
  assign flash_mode_o = flash_mode_control_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_launch;
    state_reg == ST_IDLE && start_pulse;
  endsequence

  AST_MODE_NEVER3: assert property (@(posedge clk_i) disable iff (rst_i)
    flash_mode_control_reg != 2'h3) else $error("mode reached prohibited value");
  AST_LAUNCH_RUN: assert property (@(posedge clk_i) disable iff (rst_i)
    s_launch |=> state_reg == ST_RUN) else $error("launch did not enter run");
  AST_ONE_IRQ: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_reg |=> !irq_reg) else $error("interrupt longer than one cycle");
  AST_IRQ_CAUSE: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_reg |-> $past(state_reg) == ST_RUN) else $error("interrupt without command");
  AST_NO_RELAUNCH: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == ST_RUN && wr_acc && paddr_i == OFS_MAINCMD) |=> $stable(main_cmd_reg))
    else $error("command replaced while busy");
  AST_ABORT_DONE: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == ST_RUN && force_stop_i && cmd_bus.busy) |-> ##[1:2] irq_reg)
    else $error("forced stop gave no interrupt");
  AST_START_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_acc && paddr_i == OFS_START) |=> start_address_upper_reg == $past(pwdata_i[15:0]))
    else $error("start address not stored");
  AST_WINFLAG: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(window_protect_flag_reg) |-> $past(start_pulse)) else $error("flag without command");
endmodule : fcs_sequencer

// ==== fcs_pkg.sv ====
// Package for the flash command sequencer: register map, fields, codes, timing.
// Assumes a 32-bit APB slave with byte addresses at aligned words.
package fcs_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_CLKSET = 8'h04;
  localparam logic [7:0] OFS_MAINCMD = 8'h08;
  localparam logic [7:0] OFS_EXTCMD = 8'h0C;
  localparam logic [7:0] OFS_START = 8'h10;
  localparam logic [7:0] OFS_END = 8'h14;
  localparam logic [7:0] OFS_ERRADDR = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  localparam logic [7:0] OFS_PROTECT = 8'h20;
  localparam logic [7:0] OFS_WBUF = 8'h30;
  localparam logic [7:0] OFS_UID = 8'h40;
  localparam logic [7:0] OFS_BLOCK_MASK = 8'hF0;
  localparam logic [7:0] OFS_WORD_MASK = 8'h0C;
  // ----------------------------------------------------------------
  // Modes and command codes
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_READ = 2'h0;
  localparam logic [1:0] MODE_CODE_PE = 2'h1;
  localparam logic [1:0] MODE_DATA_PE = 2'h2;
  localparam logic [3:0] CMD_PROGRAM = 4'h1;
  localparam logic [3:0] CMD_BLANK = 4'h3;
  localparam logic [3:0] CMD_BLOCK_ERASE = 4'h4;
  localparam logic [3:0] CMD_ALL_ERASE = 4'h6;
  localparam logic [2:0] XCMD_STARTUP = 3'h1;
  localparam logic [2:0] XCMD_WINDOW = 3'h2;
  // ----------------------------------------------------------------
  // Address decode: upper halves of code and data flash ranges
  // ----------------------------------------------------------------
  localparam logic [15:0] CODE_UPPER_LO = 16'hFFFC;
  localparam logic [15:0] DATA_UPPER = 16'h0010;
  localparam logic [15:0] BOOT_UPPER_HI = 16'hFFFC;
  // Status bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_ERR = 2;
  localparam int ST_WINPROT = 3;
  localparam int ST_BGO = 4;
  // Nominal operation time
  localparam int OP_TIME_US = 10;
  localparam int CLK_MHZ = 25;
  localparam int OP_CYCLES = OP_TIME_US * CLK_MHZ;
  localparam logic [31:0] UID_SEED = 32'h5A5A0000; // Arbitrary value
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_FINISH} fcs_state_type;
endpackage : fcs_pkg

// ==== fcs_cmd_if.sv ====
// Interface between the sequencer and its operation timer.
// Assumes both ends share clk_i.
`timescale 1ns/1ps
interface fcs_cmd_if;
  logic start;
  logic abort;
  logic done;
  logic busy;
  modport ctrl (output start, output abort, input done, input busy);
  modport timer (input start, input abort, output done, output busy);
endinterface : fcs_cmd_if

// ==== fcs_op_timer.sv ====
// Operation timer: counts the duration of a flash operation.
// Assumes start is a one-cycle pulse from the sequencer.
`timescale 1ns/1ps
module fcs_op_timer #(
  parameter int CYCLES = fcs_pkg::OP_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  fcs_cmd_if.timer cmd
);
  import fcs_pkg::*;
  logic [15:0] cnt_reg;
  logic busy_reg;
  logic done_reg;
  // Count down; abort ends early but still reports done
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= 16'h0000;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (cmd.start && !busy_reg) begin
        cnt_reg <= 16'(CYCLES);
        busy_reg <= 1'b1;
      end else if (busy_reg && (cmd.abort || cnt_reg == 16'h0001)) begin
        busy_reg <= 1'b0;
        done_reg <= 1'b1;
      end else if (busy_reg) begin
        cnt_reg <= cnt_reg - 16'h0001;
      end
    end
  end
  assign cmd.done = done_reg;
  assign cmd.busy = busy_reg;
endmodule : fcs_op_timer

// ==== fcs_uid_rom.sv ====
// Unique identifier words: four read-only 32-bit values.
// Assumes index is stable in the cycle it is read.
`timescale 1ns/1ps
module fcs_uid_rom (
  input wire logic [1:0] index_i,
  output logic [31:0] word_o
);
  import fcs_pkg::*;
  logic [31:0] words [4];
  // One word per index, each seeded from an arbitrary constant
  for (genvar g = 0; g < 4; g++) begin : g_uid
    assign words[g] = UID_SEED | 32'(g);
  end
  assign word_o = words[index_i];
endmodule : fcs_uid_rom

// ==== fcs_sequencer_bench.sv ====
// Self-checking bench for the flash command sequencer top module.
// Assumes the design files and fcs_pkg are compiled first; drives APB itself.
`timescale 1ns/1ps
module fcs_sequencer_bench;
  import fcs_pkg::*;
  // ----------------------------------------------------------------
  // Signals and design under test
  // ----------------------------------------------------------------
  // Short run, still long enough for overlapping writes to land inside it
  localparam int OP_LEN = 20;
  logic clk_i;
  logic rst_i;
  logic psel, penable, pwrite, force_stop;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata_o, rd;
  logic pready_o, pslverr_o, er;
  logic command_done_interrupt_o, background_operation_o, code_fetch_ok_o;
  logic [1:0] flash_mode_o;
  int fails = 0;
  int total_checks = 0;
  int irq_cnt = 0;

  fcs_sequencer #(.DATA_LAST_UPPER(16'h0010), .OP_LEN(OP_LEN)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .force_stop_i(force_stop),
    .command_done_interrupt_o(command_done_interrupt_o),
    .background_operation_o(background_operation_o),
    .code_fetch_ok_o(code_fetch_ok_o), .flash_mode_o(flash_mode_o));

  // Clock at 25 MHz, inside the allowed flash clock span
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // Interrupt pulses counted so doubles or misses show up
  always @(posedge clk_i) begin
    if (rst_i) irq_cnt <= 0;
    else if (command_done_interrupt_o === 1'b1) irq_cnt <= irq_cnt + 1;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task chk32(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk32

  task chk1(input logic got, input logic exp, input string m);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk1

  // One APB transfer; request held until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (n >= 50) chk1(1'b0, 1'b1, "no pready");
    rd = prdata_o;
    er = pslverr_o;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rdc(input logic [7:0] a, input logic [31:0] exp, input string m);
    apb(1'b0, a, 32'h0);
    chk32(rd, exp, m);
  endtask : rdc

  // Wait for the next pulse, then make sure no second one follows
  task wait_irq(input int n_exp);
    int base;
    int k;
    base = irq_cnt;
    k = 0;
    while (irq_cnt == base && k < 80) begin
      @(posedge clk_i);
      k++;
    end
    repeat (40) @(posedge clk_i);
    chk1(irq_cnt - base == n_exp, 1'b1, "interrupt count");
  endtask : wait_irq

  // Poll busy until it drops, bounded
  task wait_idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end while (rd[ST_BUSY] !== 1'b0 && n < 40);
    chk1(rd[ST_BUSY], 1'b0, "still busy");
  endtask : wait_idle

  // Launch one main command on a one-block range
  task launch(input logic [15:0] up, input logic [3:0] code);
    wr(OFS_STATUS, 32'h6);
    wr(OFS_START, {16'h0, up});
    wr(OFS_END, {16'h0, up});
    wr(OFS_MAINCMD, {28'h0, code});
  endtask : launch

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset();
    chk32({30'h0, flash_mode_o}, 32'h0, "mode after reset");
    chk1(code_fetch_ok_o, 1'b1, "fetch after reset");
    chk1(background_operation_o, 1'b0, "bgo after reset");
    for (int i = 0; i < 4; i++) begin
      wr(OFS_UID + 8'(4 * i), 32'hFFFF_FFFF);
      rdc(OFS_UID + 8'(4 * i), UID_SEED | 32'(i), "uid word");
    end
    apb(1'b0, 8'h80, 32'h0);
    chk1(er, 1'b1, "unmapped read error");
    $display("test reset done");
  endtask : t_reset

  task t_mode();
    for (int m = 0; m < 3; m++) begin
      wr(OFS_MODE, 32'(m));
      @(posedge clk_i);
      chk32({30'h0, flash_mode_o}, 32'(m), "mode field");
      chk1(code_fetch_ok_o, m != 1, "fetch per mode");
    end
    wr(OFS_MODE, 32'h1);
    wr(OFS_MODE, 32'h3);
    @(posedge clk_i);
    chk32({30'h0, flash_mode_o}, 32'h1, "mode three ignored");
    $display("test mode done");
  endtask : t_mode

  task t_regs();
    wr(OFS_START, 32'hFFFF_FFFF);
    rdc(OFS_START, 32'h0000_FFFF, "start width");
    wr(OFS_END, 32'hFFFF_FFFF);
    rdc(OFS_END, 32'h0000_FFFF, "end width");
    wr(OFS_CLKSET, 32'hFFFF_FFFF);
    rdc(OFS_CLKSET, 32'h0000_003F, "clock notification width");
    for (int i = 0; i < 4; i++) wr(OFS_WBUF + 8'(4 * i), 32'hC3A5_0000 + 32'(i));
    for (int i = 0; i < 4; i++) begin
      rdc(OFS_WBUF + 8'(4 * i), 32'hC3A5_0000 + 32'(i), "write buffer");
    end
    $display("test registers done");
  endtask : t_regs

  task t_cmds();
    logic [3:0] codes [4];
    codes = '{CMD_PROGRAM, CMD_BLANK, CMD_BLOCK_ERASE, CMD_ALL_ERASE};
    wr(OFS_MODE, {30'h0, MODE_CODE_PE});
    wr(OFS_PROTECT, 32'h0000_FF00);
    foreach (codes[i]) begin
      launch(16'hFFFD, codes[i]);
      wait_irq(1);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk1(rd[ST_DONE], 1'b1, "done bit");
      chk1(rd[ST_ERR], 1'b0, "no error");
    end
    wr(OFS_STATUS, 32'h6);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk1(rd[ST_DONE], 1'b0, "done cleared");
    launch(16'hFFFD, 4'h2);
    wait_irq(0);
    launch(16'hFFFD, 4'h5);
    wait_irq(0);
    $display("test commands done");
  endtask : t_cmds

  task t_busy();
    launch(16'hFFFD, CMD_PROGRAM);
    wr(OFS_MAINCMD, {28'h0, CMD_BLOCK_ERASE});
    wr(OFS_MODE, {30'h0, MODE_DATA_PE});
    chk32({30'h0, flash_mode_o}, {30'h0, MODE_CODE_PE}, "mode held while busy");
    wait_irq(1);
    rdc(OFS_MAINCMD, {28'h0, CMD_PROGRAM}, "command kept while busy");
    $display("test busy done");
  endtask : t_busy

  task t_protect();
    wr(OFS_PROTECT, 32'h0001_FF00);
    launch(16'hFFFC, CMD_PROGRAM);
    wait_idle();
    chk1(rd[ST_ERR], 1'b1, "start-up block refused");
    rdc(OFS_ERRADDR, 32'h0000_FFFC, "error address");
    // Window FD..FE inside the code flash range, protection off
    wr(OFS_PROTECT, 32'h0000_FEFD);
    launch(16'hFFFD, CMD_PROGRAM);
    wait_idle();
    chk1(rd[ST_ERR], 1'b0, "inside window accepted");
    launch(16'hFFFF, CMD_PROGRAM);
    wait_idle();
    chk1(rd[ST_ERR], 1'b1, "outside window refused");
    rdc(OFS_ERRADDR, 32'h0000_FFFF, "error address window");
    $display("test protect done");
  endtask : t_protect

  task t_data();
    wr(OFS_MODE, {30'h0, MODE_DATA_PE});
    launch(16'h0010, CMD_PROGRAM);
    @(posedge clk_i);
    chk1(background_operation_o, 1'b1, "bgo running");
    chk1(code_fetch_ok_o, 1'b1, "fetch during data p/e");
    wait_irq(1);
    chk1(background_operation_o, 1'b0, "bgo ended");
    wr(OFS_STATUS, 32'h6);
    wr(OFS_END, 32'h0000_0011);
    wr(OFS_MAINCMD, {28'h0, CMD_PROGRAM});
    wait_idle();
    chk1(rd[ST_ERR], 1'b1, "beyond data flash");
    wr(OFS_MODE, {30'h0, MODE_READ});
    launch(16'h0010, CMD_PROGRAM);
    wait_irq(0);
    $display("test data done");
  endtask : t_data

  task t_extra();
    wr(OFS_MODE, {30'h0, MODE_CODE_PE});
    // Error left by the refused read-mode command is cleared first
    wr(OFS_STATUS, 32'h6);
    rdc(OFS_STATUS, 32'h0, "flag clear");
    wr(OFS_EXTCMD, {29'h0, XCMD_WINDOW});
    wait_irq(1);
    wr(OFS_EXTCMD, {29'h0, 3'h3});
    wait_irq(0);
    wr(OFS_EXTCMD, {29'h0, XCMD_STARTUP});
    wait_irq(1);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk1(rd[ST_WINPROT], 1'b1, "window protect flag");
    $display("test extra done");
  endtask : t_extra

  task t_stop();
    wr(OFS_PROTECT, 32'h0000_FF00);
    launch(16'hFFFD, CMD_BLOCK_ERASE);
    force_stop <= 1'b1;
    wait_irq(1);
    force_stop <= 1'b0;
    wait_idle();
    $display("test stop done");
  endtask : t_stop

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  // Watchdog well beyond the roughly 1500 cycles the tests need
  initial begin
    repeat (40000) @(posedge clk_i);
    fails++;
    report_and_stop();
  end

  initial begin
    rst_i = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    force_stop = 1'b0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_mode();
    t_regs();
    t_cmds();
    t_busy();
    t_protect();
    t_data();
    t_extra();
    t_stop();
    report_and_stop();
  end
endmodule : fcs_sequencer_bench
